// [hdl/timer_pin_io_control.sv]
// What this block does
// R1: With the field top bit 0 the register compares, and low bits 00 leave its pin undriven.
// R2: Compare code 01 drives the pin low at each match, initial level given by field bit 2.
// R3: Compare code 10 drives the pin high at each match, initial level given by field bit 2.
// R4: Compare code 11 inverts the pin at each match, starting from the level of field bit 2.
// R5: Top bit 1 with low bits 00 captures the counter on a rising pin edge.
// R6: Top bit 1 with low bits 01 captures on a falling pin edge.
// R7: Top bit 1 with bit 1 set captures on both edges whatever bit 0 holds.
// R8: Register B of channel 2 captures from its pin B and ignores field bit 6 when bit 7 is 1.
// R9: Software never writes channel 1's A field with bits 3 and 2 both set; it captures from pin A.
// R10: Register A of channel 2 captures from its pin A and ignores field bit 2 when bit 3 is 1.
// R11: The initial pin level takes effect only while the channel's counter is stopped.
// R12: A match (counter equals register) or a capture sets the register's status flag.
// R13: A disabled compare code or the capture role leaves the pin undriven.
// R14: Reset clears every control field, leaving compare role with outputs disabled.
`timescale 1ns/10ps
module timer_pin_io_control (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  output      logic        irq,
  input  wire logic        pin_a_ch1_in,
  output      logic        pin_a_ch1_out,
  output      logic        pin_a_ch1_oe,
  input  wire logic        pin_a_ch2_in,
  output      logic        pin_a_ch2_out,
  output      logic        pin_a_ch2_oe,
  input  wire logic        pin_b_ch2_in,
  output      logic        pin_b_ch2_out,
  output      logic        pin_b_ch2_oe
);

  localparam int unsigned NU = timer_pin_io_pkg::N_UNIT;
  localparam int unsigned NC = timer_pin_io_pkg::N_CH;

  timer_pin_io_pkg::apb_state_t state_r;
  timer_pin_io_pkg::apb_state_t state_nxt;

  logic [7:0]    pin_io_control_ch1_r;
  logic [7:0]    pin_io_control_ch2_r;
  logic [NC-1:0] timer_start_reg_r;
  logic [15:0]   cnt_r     [NC];
  logic [15:0]   cnt_nxt   [NC];
  logic [NU-1:0] status_r;
  logic [NU-1:0] status_nxt;
  logic [NU-1:0] mask_r;
  logic [31:0]   prdata_r;
  logic [31:0]   rdata_mux;
  logic          pready_r;
  logic          pslverr_r;
  logic          irq_r;
  logic [NU-1:0] pin_meta_r;
  logic [NU-1:0] pin_sync_r;

  gr_unit_if u_a1 ();
  gr_unit_if u_a2 ();
  gr_unit_if u_b2 ();

  // apb phase decode
  wire setup    = psel && !penable && (state_r == timer_pin_io_pkg::APB_IDLE);
  wire access   = psel && penable && (state_r == timer_pin_io_pkg::APB_ACK);
  wire wr_en    = access && pwrite;
  wire rd_en    = access && !pwrite;

  // address decode
  wire sel_ctl1 = (paddr == timer_pin_io_pkg::OFS_CTL_CH1);
  wire sel_ctl2 = (paddr == timer_pin_io_pkg::OFS_CTL_CH2);
  wire sel_strt = (paddr == timer_pin_io_pkg::OFS_START);
  wire sel_cnt1 = (paddr == timer_pin_io_pkg::OFS_CNT_CH1);
  wire sel_cnt2 = (paddr == timer_pin_io_pkg::OFS_CNT_CH2);
  wire sel_gra1 = (paddr == timer_pin_io_pkg::OFS_GR_A_CH1);
  wire sel_gra2 = (paddr == timer_pin_io_pkg::OFS_GR_A_CH2);
  wire sel_grb2 = (paddr == timer_pin_io_pkg::OFS_GR_B_CH2);
  wire sel_stat = (paddr == timer_pin_io_pkg::OFS_STATUS);
  wire sel_mask = (paddr == timer_pin_io_pkg::OFS_MASK);
  wire mapped   = sel_ctl1 | sel_ctl2 | sel_strt | sel_cnt1 | sel_cnt2 |
                  sel_gra1 | sel_gra2 | sel_grb2 | sel_stat | sel_mask;

  // per-register control fields
  wire [3:0] ctl_a1 = pin_io_control_ch1_r[timer_pin_io_pkg::FLD_A_LSB +: 4];
  wire [3:0] ctl_a2 = pin_io_control_ch2_r[timer_pin_io_pkg::FLD_A_LSB +: 4];
  wire [3:0] ctl_b2 = pin_io_control_ch2_r[timer_pin_io_pkg::FLD_B_LSB +: 4];

  // events from the three registers, in status bit order
  wire [NU-1:0] evt = {u_b2.evt, u_a2.evt, u_a1.evt};

  // a status read clears only the bits it returned
  wire [NU-1:0] stat_clr = (rd_en && sel_stat) ? prdata_r[NU-1:0] : '0;

  // new events win over the read clear in the same cycle
  assign status_nxt = (status_r & ~stat_clr) | evt;  // see R12

  // read data mux, zero for unmapped addresses
  always_comb begin
    rdata_mux = '0;
    case (1'b1)
      sel_ctl1: rdata_mux[7:0]    = pin_io_control_ch1_r;
      sel_ctl2: rdata_mux[7:0]    = pin_io_control_ch2_r;
      sel_strt: rdata_mux[NC-1:0] = timer_start_reg_r;
      sel_cnt1: rdata_mux[15:0]   = cnt_r[0];
      sel_cnt2: rdata_mux[15:0]   = cnt_r[1];
      sel_gra1: rdata_mux[15:0]   = u_a1.gr;
      sel_gra2: rdata_mux[15:0]   = u_a2.gr;
      sel_grb2: rdata_mux[15:0]   = u_b2.gr;
      sel_stat: rdata_mux[NU-1:0] = status_r;
      sel_mask: rdata_mux[NU-1:0] = mask_r;
      default:  rdata_mux         = '0;
    endcase
  end

  // apb sequencing: zero wait states, answer in the first access cycle
  always_comb begin
    case (state_r)
      timer_pin_io_pkg::APB_IDLE: state_nxt = setup ? timer_pin_io_pkg::APB_ACK
                                                    : timer_pin_io_pkg::APB_IDLE;
      timer_pin_io_pkg::APB_ACK:  state_nxt = timer_pin_io_pkg::APB_IDLE;
      default:                    state_nxt = timer_pin_io_pkg::APB_IDLE;
    endcase
  end

  // counters: free running on pclk while started; prescaler lives elsewhere
  always_comb begin
    for (int c = 0; c < NC; c++) begin
      cnt_nxt[c] = timer_start_reg_r[c] ? 16'(cnt_r[c] + 16'h0001) : cnt_r[c];
    end
    if (wr_en && sel_cnt1) begin
      cnt_nxt[0] = pwdata[15:0];
    end
    if (wr_en && sel_cnt2) begin
      cnt_nxt[1] = pwdata[15:0];
    end
  end

  // bus slave flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= timer_pin_io_pkg::APB_IDLE;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= timer_pin_io_pkg::RDATA_RST;
    end else begin
      state_r   <= state_nxt;
      pready_r  <= setup;
      pslverr_r <= setup && !mapped;
      if (setup) begin
        prdata_r <= pwrite ? timer_pin_io_pkg::RDATA_RST : rdata_mux;
      end
    end
  end

  // software registers, written at the access edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_io_control_ch1_r <= timer_pin_io_pkg::CTL_RST;  // see R14
      pin_io_control_ch2_r <= timer_pin_io_pkg::CTL_RST;  // see R14
      timer_start_reg_r    <= timer_pin_io_pkg::START_RST;
      mask_r               <= timer_pin_io_pkg::STAT_RST;
    end else begin
      if (wr_en && sel_ctl1) begin
        pin_io_control_ch1_r <= pwdata[7:0];
      end
      if (wr_en && sel_ctl2) begin
        pin_io_control_ch2_r <= pwdata[7:0];
      end
      if (wr_en && sel_strt) begin
        timer_start_reg_r <= pwdata[NC-1:0];
      end
      if (wr_en && sel_mask) begin
        mask_r <= pwdata[NU-1:0];
      end
    end
  end

  // counters, status and interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r[0] <= timer_pin_io_pkg::CNT_RST;
      cnt_r[1] <= timer_pin_io_pkg::CNT_RST;
      status_r <= timer_pin_io_pkg::STAT_RST;
      irq_r    <= 1'b0;
    end else begin
      cnt_r[0] <= cnt_nxt[0];
      cnt_r[1] <= cnt_nxt[1];
      status_r <= status_nxt;
      irq_r    <= |(status_nxt & mask_r);
    end
  end

  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= {pin_b_ch2_in, pin_a_ch2_in, pin_a_ch1_in};
      pin_sync_r <= pin_meta_r;
    end
  end

  // register a of channel 1: capture source is its own pin a;
  // the prohibited 11xx code is treated as capture, bit 2 then ignored
  assign u_a1.cnt     = cnt_r[0];
  assign u_a1.running = timer_start_reg_r[0];
  assign u_a1.ctl     = ctl_a1;  // see R9
  assign u_a1.wr      = wr_en && sel_gra1;
  assign u_a1.wdata   = pwdata[15:0];
  assign u_a1.pin_in  = pin_sync_r[timer_pin_io_pkg::EV_A_CH1];

  // register a of channel 2, captures from pin a of channel 2
  assign u_a2.cnt     = cnt_r[1];
  assign u_a2.running = timer_start_reg_r[1];
  assign u_a2.ctl     = ctl_a2;  // see R10
  assign u_a2.wr      = wr_en && sel_gra2;
  assign u_a2.wdata   = pwdata[15:0];
  assign u_a2.pin_in  = pin_sync_r[timer_pin_io_pkg::EV_A_CH2];  // see R10

  // register b of channel 2, captures from pin b of channel 2
  assign u_b2.cnt     = cnt_r[1];
  assign u_b2.running = timer_start_reg_r[1];
  assign u_b2.ctl     = ctl_b2;  // see R8
  assign u_b2.wr      = wr_en && sel_grb2;
  assign u_b2.wdata   = pwdata[15:0];
  assign u_b2.pin_in  = pin_sync_r[timer_pin_io_pkg::EV_B_CH2];  // see R8

  // capture edge selection and role decode live in the unit
  // see R5 see R6 see R7
  gr_unit i_gr_a1 (
    .pclk    (pclk),
    .presetn (presetn),
    .u       (u_a1)
  );

  gr_unit i_gr_a2 (
    .pclk    (pclk),
    .presetn (presetn),
    .u       (u_a2)
  );

  gr_unit i_gr_b2 (
    .pclk    (pclk),
    .presetn (presetn),
    .u       (u_b2)
  );

  // outputs straight from flops
  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
  assign irq           = irq_r;
  assign pin_a_ch1_out = u_a1.pin_out;
  assign pin_a_ch1_oe  = u_a1.pin_oe;
  assign pin_a_ch2_out = u_a2.pin_out;
  assign pin_a_ch2_oe  = u_a2.pin_oe;
  assign pin_b_ch2_out = u_b2.pin_out;
  assign pin_b_ch2_oe  = u_b2.pin_oe;

endmodule // timer_pin_io_control

// [include/timer_pin_io_pkg.sv]
package timer_pin_io_pkg;

  // widths
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned CTL_W  = 4;
  localparam int unsigned N_UNIT = 3;
  localparam int unsigned N_CH   = 2;

  // register byte offsets on the apb
  localparam logic [7:0] OFS_CTL_CH1  = 8'h00;
  localparam logic [7:0] OFS_CTL_CH2  = 8'h04;
  localparam logic [7:0] OFS_START    = 8'h08;
  localparam logic [7:0] OFS_CNT_CH1  = 8'h0c;
  localparam logic [7:0] OFS_CNT_CH2  = 8'h10;
  localparam logic [7:0] OFS_GR_A_CH1 = 8'h14;
  localparam logic [7:0] OFS_GR_A_CH2 = 8'h18;
  localparam logic [7:0] OFS_GR_B_CH2 = 8'h1c;
  localparam logic [7:0] OFS_STATUS   = 8'h20;
  localparam logic [7:0] OFS_MASK     = 8'h24;

  // control field layout inside a pin_io_control register
  localparam int unsigned FLD_A_LSB     = 0;
  localparam int unsigned FLD_B_LSB     = 4;
  localparam int unsigned CTL_TOP_BIT   = 3;
  localparam int unsigned CTL_INIT_BIT  = 2;
  localparam int unsigned CTL_BOTH_BIT  = 1;
  localparam int unsigned CTL_FALL_BIT  = 0;

  // compare actions, low two field bits
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_CLR = 2'h1;
  localparam logic [1:0] ACT_SET = 2'h2;
  localparam logic [1:0] ACT_TGL = 2'h3;

  // status and mask bit positions: one bit per general register
  localparam int unsigned EV_A_CH1 = 0;
  localparam int unsigned EV_A_CH2 = 1;
  localparam int unsigned EV_B_CH2 = 2;

  // reset values
  localparam logic [7:0]        CTL_RST   = 8'h00;
  localparam logic [N_CH-1:0]   START_RST = 2'h0;
  localparam logic [CNT_W-1:0]  CNT_RST   = 16'h0000;
  localparam logic [CNT_W-1:0]  GR_RST    = 16'h0000;
  localparam logic [N_UNIT-1:0] STAT_RST  = 3'h0;
  localparam logic [31:0]       RDATA_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_ACK  = 2'b10
  } apb_state_t;

  // top bit set selects capture role
  function automatic logic ctl_capture(input logic [CTL_W-1:0] ctl);
    return ctl[CTL_TOP_BIT];
  endfunction

  // pin driven only in compare role with a non-off action
  function automatic logic ctl_drives(input logic [CTL_W-1:0] ctl);
    return !ctl[CTL_TOP_BIT] && (ctl[1:0] != ACT_OFF);
  endfunction

  // edge select: both, falling, else rising
  function automatic logic ctl_edge_hit(input logic [CTL_W-1:0] ctl,
                                        input logic prev,
                                        input logic cur);
    if (ctl[CTL_BOTH_BIT]) begin
      return prev != cur;
    end else if (ctl[CTL_FALL_BIT]) begin
      return prev && !cur;
    end
    return !prev && cur;
  endfunction

endpackage

// [include/gr_unit_if.sv]
`timescale 1ns/10ps
interface gr_unit_if;
  logic [15:0] cnt;
  logic        running;
  logic [3:0]  ctl;
  logic        wr;
  logic [15:0] wdata;
  logic        pin_in;
  logic [15:0] gr;
  logic        evt;
  logic        pin_out;
  logic        pin_oe;

  modport unit (input cnt, input running, input ctl, input wr, input wdata, input pin_in,
                output gr, output evt, output pin_out, output pin_oe);
  modport ctrl (output cnt, output running, output ctl, output wr, output wdata,
                output pin_in, input gr, input evt, input pin_out, input pin_oe);
endinterface

// [hdl/gr_unit.sv]
`timescale 1ns/10ps
// one general register with its compare/capture pin logic
module gr_unit (
  input wire logic pclk,
  input wire logic presetn,
  gr_unit_if.unit  u
);

  logic [15:0] gr_r;
  logic [15:0] gr_nxt;
  logic        prev_r;
  logic        evt_r;
  logic        out_r;
  logic        out_nxt;
  logic        oe_r;

  wire is_cap   = timer_pin_io_pkg::ctl_capture(u.ctl);
  // a match can only fire while the counter moves, so it lasts one cycle
  wire match    = !is_cap && u.running && (u.cnt == gr_r);  // see R12
  wire edge_hit = is_cap && timer_pin_io_pkg::ctl_edge_hit(u.ctl, prev_r, u.pin_in);

  // capture beats a software write in the same cycle
  assign gr_nxt = edge_hit ? u.cnt : (u.wr ? u.wdata : gr_r);  // see R12

  // pin level: initial level while stopped, compare action while running
  always_comb begin
    out_nxt = out_r;
    if (!u.running) begin
      out_nxt = u.ctl[timer_pin_io_pkg::CTL_INIT_BIT];  // see R11
    end else if (match) begin
      case (u.ctl[1:0])
        timer_pin_io_pkg::ACT_CLR: out_nxt = 1'b0;    // see R2
        timer_pin_io_pkg::ACT_SET: out_nxt = 1'b1;    // see R3
        timer_pin_io_pkg::ACT_TGL: out_nxt = ~out_r;  // see R4
        default:                   out_nxt = out_r;
      endcase
    end
  end

  // state flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gr_r   <= timer_pin_io_pkg::GR_RST;
      prev_r <= 1'b0;
      evt_r  <= 1'b0;
      out_r  <= 1'b0;
      oe_r   <= 1'b0;
    end else begin
      gr_r   <= gr_nxt;
      prev_r <= u.pin_in;
      evt_r  <= match | edge_hit;
      out_r  <= out_nxt;
      oe_r   <= timer_pin_io_pkg::ctl_drives(u.ctl);  // see R1 see R13
    end
  end

  assign u.gr      = gr_r;
  assign u.evt     = evt_r;
  assign u.pin_out = out_r;
  assign u.pin_oe  = oe_r;

endmodule // gr_unit

// [testbench/pin_partner.sv]
`timescale 1ns/10ps
// far side of the three compare/capture pins
module pin_partner (
  input  wire logic [2:0] out,
  input  wire logic [2:0] oe,
  input  wire logic [2:0] ext,
  output      logic [2:0] lvl
);
  // the device wins while it drives; otherwise the outside source sets the wire
  assign lvl = (oe & out) | (~oe & ext);
endmodule // pin_partner

// [testbench/timer_pin_io_control_monitor.sv]
`timescale 1ns/10ps
module timer_pin_io_control_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        pin_a_ch1_out,
  input wire logic        pin_a_ch1_oe,
  input wire logic        pin_a_ch2_out,
  input wire logic        pin_b_ch2_oe
);
  logic [7:0] c1_r;
  logic [7:0] c2_r;
  logic [1:0] run_r;
  logic [2:0] msk_r;
  wire        wr = psel && penable && pready && pwrite;
  // shadow copies of the controls, since the checker sees only the bus and the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_r <= 8'h00;
      c2_r <= 8'h00;
      run_r <= 2'h0;
      msk_r <= 3'h0;
    end else begin
      if (wr && paddr == timer_pin_io_pkg::OFS_CTL_CH1) c1_r <= pwdata[7:0];
      if (wr && paddr == timer_pin_io_pkg::OFS_CTL_CH2) c2_r <= pwdata[7:0];
      if (wr && paddr == timer_pin_io_pkg::OFS_START) run_r <= pwdata[1:0];
      if (wr && paddr == timer_pin_io_pkg::OFS_MASK) msk_r <= pwdata[2:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PREADY: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_SLVERR: assert property (psel && !penable && paddr > 8'h24 |=> pready && pslverr)
    else $error("unmapped access not refused");
  AST_OE_A1: assert property (c1_r == $past(c1_r) && c1_r == $past(c1_r, 2)
    |-> pin_a_ch1_oe == (!c1_r[3] && c1_r[1:0] != 2'h0)) else $error("pin a1 enable wrong");
  AST_OE_B2: assert property (c2_r == $past(c2_r) && c2_r == $past(c2_r, 2)
    |-> pin_b_ch2_oe == (!c2_r[7] && c2_r[5:4] != 2'h0)) else $error("pin b2 enable wrong");
  AST_INIT_A2: assert property (!run_r[1] && !$past(run_r[1]) && !$past(run_r[1], 2)
    && c2_r == $past(c2_r, 2) |-> pin_a_ch2_out == c2_r[2]) else $error("initial level wrong");
  AST_CLR_NO_RISE: assert property (run_r[0] && $past(run_r[0], 2) && !c1_r[3]
    && c1_r[1:0] == 2'h1 && c1_r == $past(c1_r, 2) |-> !$rose(pin_a_ch1_out))
    else $error("clear action raised pin");
  AST_SET_NO_FALL: assert property (run_r[0] && $past(run_r[0], 2) && !c1_r[3]
    && c1_r[1:0] == 2'h2 && c1_r == $past(c1_r, 2) |-> !$fell(pin_a_ch1_out))
    else $error("set action lowered pin");
  AST_IRQ_MASK: assert property (msk_r == 3'h0 && $past(msk_r) == 3'h0 |-> !irq)
    else $error("interrupt while all masked");
endmodule // timer_pin_io_control_monitor

bind timer_pin_io_control timer_pin_io_control_monitor u_timer_pin_io_control_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .pin_a_ch1_out(pin_a_ch1_out), .pin_a_ch1_oe(pin_a_ch1_oe),
  .pin_a_ch2_out(pin_a_ch2_out), .pin_b_ch2_oe(pin_b_ch2_oe)
);

// [testbench/tb_timer_pin_io_control.sv]
`timescale 1ns/10ps
module tb_timer_pin_io_control;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [2:0]  ext = 3'h0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         irq;
  wire  [2:0]  po;
  wire  [2:0]  oe;
  wire  [2:0]  pin_in;
  logic [31:0] q;
  logic        serr;
  logic        lv;
  int          errors = 0;
  int          comparisons = 0;
  int          n;

  timer_pin_io_control u_timer_pin_io_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .pin_a_ch1_in(pin_in[0]), .pin_a_ch1_out(po[0]), .pin_a_ch1_oe(oe[0]),
    .pin_a_ch2_in(pin_in[1]), .pin_a_ch2_out(po[1]), .pin_a_ch2_oe(oe[1]),
    .pin_b_ch2_in(pin_in[2]), .pin_b_ch2_out(po[2]), .pin_b_ch2_oe(oe[2])
  );
  pin_partner u_pin_partner (.out(po), .oe(oe), .ext(ext), .lvl(pin_in));

  always #4 pclk = ~pclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; an idle cycle first keeps each strobe to one change per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // look at ready between edges, where it has settled; the next rising edge completes
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    q = prdata;
    serr = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask

  task automatic report_and_stop;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // watchdog: the tests need about 570 cycles
  initial begin
    #200000;
    errors++;
    report_and_stop;
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk({29'h0, oe}, 32'h0);
    for (int a = 0; a <= 'h24; a += 4) rd(8'(a), 32'h0);
    rd(8'h40, 32'h0);
    chk({31'h0, serr}, 32'h1);
    wr(timer_pin_io_pkg::OFS_CTL_CH1, 32'hffff_ff5a);
    rd(timer_pin_io_pkg::OFS_CTL_CH1, 32'h5a);
    $display("test registers done");
    // compare codes on channel 1 register a, match at count 5
    wr(timer_pin_io_pkg::OFS_MASK, 32'h1);
    for (int c = 0; c < 8; c++) begin
      wr(timer_pin_io_pkg::OFS_START, 32'h0);
      wr(timer_pin_io_pkg::OFS_CTL_CH1, 32'(c));
      wr(timer_pin_io_pkg::OFS_GR_A_CH1, 32'h5);
      wr(timer_pin_io_pkg::OFS_CNT_CH1, 32'h0);
      chk({oe[0], po[0] & oe[0]}, {c[1:0] != 2'h0, c[2] & (c[1:0] != 2'h0)});
      wr(timer_pin_io_pkg::OFS_START, 32'h1);
      n = 0;
      while (irq !== 1'b1 && n < 40) begin
        @(posedge pclk);
        n++;
      end
      chk({31'h0, irq}, 32'h1);
      lv = (c[1:0] == 2'h1) ? 1'b0 : (c[1:0] == 2'h2) ? 1'b1 : !c[2];
      chk({oe[0], po[0] & oe[0]}, {c[1:0] != 2'h0, lv & (c[1:0] != 2'h0)});
      rd(timer_pin_io_pkg::OFS_STATUS, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
    end
    $display("test compare done");
    // capture codes on all three registers, interrupt masked
    wr(timer_pin_io_pkg::OFS_MASK, 32'h0);
    for (int c = 8; c < 16; c++) begin
      wr(timer_pin_io_pkg::OFS_START, 32'h0);
      wr(timer_pin_io_pkg::OFS_CTL_CH1, 32'(c & 'hb));
      wr(timer_pin_io_pkg::OFS_CTL_CH2, {24'h0, c[3:0], c[3:0]});
      wr(timer_pin_io_pkg::OFS_START, 32'h3);
      ext <= 3'h7;
      repeat (8) @(posedge pclk);
      chk({28'h0, oe, irq}, 32'h0);
      rd(timer_pin_io_pkg::OFS_STATUS, {29'h0, {3{c[1] | !c[0]}}});
      ext <= 3'h0;
      repeat (8) @(posedge pclk);
      rd(timer_pin_io_pkg::OFS_STATUS, {29'h0, {3{c[1] | c[0]}}});
    end
    $display("test capture done");
    // channel 2 compare: clear action from a high initial level on pins a and b
    wr(timer_pin_io_pkg::OFS_START, 32'h0);
    wr(timer_pin_io_pkg::OFS_CTL_CH2, 32'h55);
    wr(timer_pin_io_pkg::OFS_GR_A_CH2, 32'h3);
    wr(timer_pin_io_pkg::OFS_GR_B_CH2, 32'h3);
    wr(timer_pin_io_pkg::OFS_CNT_CH2, 32'h0);
    chk({28'h0, oe[2:1], po[2:1]}, 32'hf);
    wr(timer_pin_io_pkg::OFS_START, 32'h2);
    repeat (10) @(posedge pclk);
    chk({28'h0, oe[2:1], po[2:1]}, 32'hc);
    rd(timer_pin_io_pkg::OFS_STATUS, 32'h6);
    $display("test channel 2 compare done");
    report_and_stop;
  end
endmodule // tb_timer_pin_io_control
